// file: logic/rfidth_handler.sv
// Telegram command handler: output and input telegram registers on Wishbone,
// toggle-bit handshaking, command decode, single and repeating execution.
// Assumes a head front end that takes a one-cycle request and answers later
// with a one-cycle done pulse carrying status, word count and data.
`timescale 1ns/1ns
`default_nettype none

// Function
// (R01) Master acknowledge equals inverted slave update
// (R02) Master toggles update only after acknowledge
// (R03) Update bit change accepts command, echoed inverted
// (R04) Delete bit change discards pending response
// (R05) Response holds code, parameter, status, counter, data; the response word has word count, not parameter
// (R06) Unused command data fields are ignored
// (R07) Good read reports status zero, word count
// (R08) Write and fixed-id reads report count zero
// (R09) Master waits for response before next command
// (R10) Repeating command runs until another arrives
// (R11) Reply counter zero at reset, counts responses
// (R12) Reply counter wraps from ff to 01
// (R13) Single command runs once, answers immediately
// (R14) Repeating command answers, stays active until error
// (R15) Repeating mode reports only changed tags
// (R16) Tag leaving range reports status five
// (R17) System command codes decode
// (R18) Fixed-id and word read codes decode
// (R19) Word write and locked write codes decode
// (R20) Password command codes decode
// (R21) Tag configuration codes decode
// (R22) Identifier programming codes decode
// (R23) Special identifier codes decode
// (R24) Head parameter codes decode
module rfidth_handler (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic head_req_o,
   output logic [7:0] head_code_o,
   output logic [31:0] head_param_o,
   output logic [31:0] head_data_o,
   output logic repeat_active_o,
   input wire logic head_done_i,
   input wire logic [7:0] head_status_i,
   input wire logic [7:0] head_count_i,
   input wire logic [31:0] head_data_i,
   input wire logic head_present_i
);
   // (R17) system codes
   // (R18) read codes
   // (R19) write codes
   // (R20) password codes
   // (R21) configuration codes
   // (R22) identifier codes
   // (R23) special codes
   // (R24) head parameter codes
   function automatic logic cmd_repeat(input logic [7:0] c);
      return c inside {rfidth_pkg::repeat_fixed_id_read, rfidth_pkg::repeat_word_read,
         rfidth_pkg::repeat_word_write, rfidth_pkg::repeat_locked_word_write,
         rfidth_pkg::repeat_config_get, rfidth_pkg::repeat_config_write,
         rfidth_pkg::repeat_fixed_id_write, rfidth_pkg::repeat_special_id_read,
         rfidth_pkg::repeat_special_id_program};
   endfunction : cmd_repeat

   function automatic logic cmd_reads(input logic [7:0] c);
      return c inside {rfidth_pkg::single_word_read, rfidth_pkg::repeat_word_read,
         rfidth_pkg::single_config_get, rfidth_pkg::repeat_config_get,
         rfidth_pkg::single_special_id_read, rfidth_pkg::repeat_special_id_read,
         rfidth_pkg::head_param_read};
   endfunction : cmd_reads

   function automatic logic cmd_uses_data(input logic [7:0] c);
      return c inside {rfidth_pkg::single_word_write, rfidth_pkg::repeat_word_write,
         rfidth_pkg::single_locked_word_write, rfidth_pkg::repeat_locked_word_write,
         rfidth_pkg::password_change_cmd, rfidth_pkg::password_supply_cmd,
         rfidth_pkg::single_config_write, rfidth_pkg::repeat_config_write,
         rfidth_pkg::single_fixed_id_write, rfidth_pkg::repeat_fixed_id_write,
         rfidth_pkg::tag_identifier_set, rfidth_pkg::tag_fill_cmd,
         rfidth_pkg::single_special_id_program, rfidth_pkg::repeat_special_id_program,
         rfidth_pkg::tag_init_cmd, rfidth_pkg::head_param_write};
   endfunction : cmd_uses_data

   function automatic logic cmd_known(input logic [7:0] c);
      return cmd_repeat(c) || cmd_reads(c) || cmd_uses_data(c) ||
         c inside {rfidth_pkg::select_tag_type_cmd, rfidth_pkg::quit_cmd,
         rfidth_pkg::config_store_cmd, rfidth_pkg::soft_reset_cmd,
         rfidth_pkg::multiplexed_mode_cmd, rfidth_pkg::trigger_mode_cmd,
         rfidth_pkg::single_fixed_id_read, rfidth_pkg::password_mode_cmd};
   endfunction : cmd_known

   logic [2:0] out_ctrl;
   logic [7:0] out_cmd;
   logic [31:0] out_param;
   logic [31:0] out_data;
   logic us_in;
   logic um_echo;
   logic ds_echo;
   logic [7:0] resp_code;
   logic [7:0] resp_stat;
   logic [7:0] resp_wc;
   logic [7:0] reply_cnt;
   logic [31:0] resp_data;
   logic pend_v;
   logic [7:0] pend_code;
   logic [7:0] pend_stat;
   logic [7:0] pend_wc;
   logic [31:0] pend_data;
   logic [31:0] last_data;
   logic last_seen;
   rfidth_pkg::rfidth_state_t st;
   rfidth_pkg::rfidth_state_t next_st;
   logic push;
   logic [7:0] next_stat;
   logic [7:0] next_wc;
   logic [31:0] next_data;
   logic wb_hit;
   logic wb_wr;
   logic del_req;
   logic can_send;
   logic publish;
   logic accept;
   logic issue;

   assign wb_hit = cyc_i && stb_i && !ack_o;
   assign wb_wr = cyc_i && stb_i && we_i && ack_o;
   assign del_req = out_ctrl[rfidth_pkg::CTL_DS] != ds_echo;
   assign can_send = out_ctrl[rfidth_pkg::CTL_US] != us_in;
   // (R03) new command detect
   assign accept = (out_ctrl[rfidth_pkg::CTL_UM] == um_echo) && !pend_v && !del_req &&
      (st == rfidth_pkg::ST_IDLE || st == rfidth_pkg::ST_RPT_IDLE);
   assign publish = pend_v && can_send && !del_req;
   // (R10) keep repeating
   assign issue = (accept && cmd_known(out_cmd)) ||
      (st == rfidth_pkg::ST_RPT_IDLE && !accept && !pend_v && !del_req);
   assign repeat_active_o = st == rfidth_pkg::ST_RPT_IDLE || st == rfidth_pkg::ST_RPT_EXEC;

   // One-cycle answer to every access; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= wb_hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (wb_hit && !we_i) begin
         unique case (adr_i)
            rfidth_pkg::ADR_OUT_CTRL: dat_o <= {29'h0, out_ctrl};
            rfidth_pkg::ADR_OUT_CMD: dat_o <= {24'h0, out_cmd};
            rfidth_pkg::ADR_OUT_PARAM: dat_o <= out_param;
            rfidth_pkg::ADR_OUT_DATA: dat_o <= out_data;
            rfidth_pkg::ADR_IN_CTRL: dat_o <= {29'h0, ds_echo, um_echo, us_in};
            // (R05) response layout
            rfidth_pkg::ADR_IN_RESP: dat_o <= {resp_wc, reply_cnt, resp_stat, resp_code};
            rfidth_pkg::ADR_IN_DATA: dat_o <= resp_data;
            default: dat_o <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_ctrl <= rfidth_pkg::OUT_CTRL_RST;
         out_cmd <= 8'h00;
      end else if (wb_wr && sel_i[0]) begin
         if (adr_i == rfidth_pkg::ADR_OUT_CTRL) begin
            out_ctrl <= dat_i[2:0];
         end
         if (adr_i == rfidth_pkg::ADR_OUT_CMD) begin
            out_cmd <= dat_i[7:0];
         end
      end
   end

   for (genvar b = 0; b < 4; b++) begin : g_lane
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            out_param[8*b +: 8] <= 8'h00;
            out_data[8*b +: 8] <= 8'h00;
         end else if (wb_wr && sel_i[b]) begin
            if (adr_i == rfidth_pkg::ADR_OUT_PARAM) begin
               out_param[8*b +: 8] <= dat_i[8*b +: 8];
            end
            if (adr_i == rfidth_pkg::ADR_OUT_DATA) begin
               out_data[8*b +: 8] <= dat_i[8*b +: 8];
            end
         end
      end
   end

   // Command latch and echo of the master update bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         um_echo <= ~rfidth_pkg::OUT_CTRL_RST[rfidth_pkg::CTL_UM];
         head_code_o <= 8'h00;
         head_param_o <= 32'h0;
         head_data_o <= 32'h0;
      end else if (accept) begin
         // (R03) echo inverted
         um_echo <= ~out_ctrl[rfidth_pkg::CTL_UM];
         head_code_o <= out_cmd;
         head_param_o <= out_param;
         // (R06) drop unused data
         head_data_o <= cmd_uses_data(out_cmd) ? out_data : 32'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         head_req_o <= 1'b0;
      end else begin
         head_req_o <= issue;
      end
   end

   always_comb begin
      next_st = st;
      push = 1'b0;
      next_stat = head_status_i;
      next_wc = rfidth_pkg::WC_NONE;
      next_data = head_data_i;
      unique case (st)
         rfidth_pkg::ST_IDLE, rfidth_pkg::ST_RPT_IDLE: begin
            if (accept && cmd_known(out_cmd)) begin
               next_st = cmd_repeat(out_cmd) ? rfidth_pkg::ST_RPT_EXEC : rfidth_pkg::ST_EXEC;
            end else if (accept) begin
               // Unknown code ends any repeat and answers at once
               push = 1'b1;
               next_stat = rfidth_pkg::ST_BAD_CMD;
               next_data = 32'h0;
               next_st = rfidth_pkg::ST_IDLE;
            end else if (issue) begin
               next_st = rfidth_pkg::ST_RPT_EXEC;
            end
         end
         rfidth_pkg::ST_EXEC: begin
            // (R13) single run answers
            if (head_done_i) begin
               push = 1'b1;
               next_st = rfidth_pkg::ST_IDLE;
               // (R07) read word count
               if (cmd_reads(head_code_o) && head_status_i == rfidth_pkg::ST_OK) begin
                  next_wc = head_count_i;
               end
            end
         end
         rfidth_pkg::ST_RPT_EXEC: begin
            if (head_done_i) begin
               next_st = rfidth_pkg::ST_RPT_IDLE;
               if (head_status_i == rfidth_pkg::ST_OK && head_present_i) begin
                  // (R15) only changed tags
                  push = !last_seen || head_data_i != last_data;
                  if (cmd_reads(head_code_o)) begin
                     next_wc = head_count_i;
                  end
               end else if (!head_present_i || head_status_i == rfidth_pkg::ST_TAG_GONE) begin
                  // (R16) tag left range
                  push = last_seen;
                  next_stat = rfidth_pkg::ST_TAG_GONE;
                  next_data = 32'h0;
               end else begin
                  // (R14) error ends repeat
                  push = 1'b1;
                  next_st = rfidth_pkg::ST_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= rfidth_pkg::ST_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Last tag reported in repeating mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_seen <= 1'b0;
         last_data <= 32'h0;
      end else if (accept) begin
         last_seen <= 1'b0;
      end else if (head_done_i && st != rfidth_pkg::ST_IDLE && st != rfidth_pkg::ST_RPT_IDLE) begin
         last_seen <= head_present_i && head_status_i == rfidth_pkg::ST_OK;
         last_data <= head_data_i;
      end
   end

   // Pending response slot; a new response wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_v <= 1'b0;
         pend_code <= 8'h00;
         pend_stat <= rfidth_pkg::ST_OK;
         pend_wc <= rfidth_pkg::WC_NONE;
         pend_data <= 32'h0;
      end else if (push) begin
         pend_v <= 1'b1;
         pend_code <= accept ? out_cmd : head_code_o;
         pend_stat <= next_stat;
         // (R08) no count on writes
         pend_wc <= next_wc;
         pend_data <= next_data;
      end else if (del_req || publish) begin
         // (R04) discard stale entry
         pend_v <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ds_echo <= rfidth_pkg::OUT_CTRL_RST[rfidth_pkg::CTL_DS];
      end else if (del_req) begin
         ds_echo <= out_ctrl[rfidth_pkg::CTL_DS];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         us_in <= 1'b0;
         reply_cnt <= rfidth_pkg::RC_RST;
         resp_code <= 8'h00;
         resp_stat <= rfidth_pkg::ST_OK;
         resp_wc <= rfidth_pkg::WC_NONE;
         resp_data <= 32'h0;
      end else if (publish) begin
         // (R05) publish response
         us_in <= ~us_in;
         resp_code <= pend_code;
         resp_stat <= pend_stat;
         resp_wc <= pend_wc;
         resp_data <= pend_data;
         // (R11) count each response
         // (R12) skip zero on wrap
         reply_cnt <= (reply_cnt == rfidth_pkg::RC_MAX) ? rfidth_pkg::RC_WRAP : reply_cnt + 8'h01;
      end
   end

   property p_um_echo;
      @(posedge clk_i) disable iff (rst_i)
      accept |=> um_echo != $past(out_ctrl[rfidth_pkg::CTL_UM]) && head_code_o == $past(out_cmd);
   endproperty
   a_um_echo: assert property (p_um_echo) else $error("update echo wrong"); // R03

   property p_delete;
      @(posedge clk_i) disable iff (rst_i)
      del_req && !push |=> !pend_v && ds_echo == $past(out_ctrl[rfidth_pkg::CTL_DS]);
   endproperty
   a_delete: assert property (p_delete) else $error("delete not honoured"); // R04

   property p_publish;
      @(posedge clk_i) disable iff (rst_i)
      publish |=> us_in != $past(us_in) && resp_code == $past(pend_code) && resp_stat == $past(pend_stat);
   endproperty
   a_publish: assert property (p_publish) else $error("response not published"); // R05

   property p_unused_data;
      @(posedge clk_i) disable iff (rst_i)
      accept && !cmd_uses_data(out_cmd) |=> head_data_o == 32'h0;
   endproperty
   a_unused_data: assert property (p_unused_data) else $error("unused data passed"); // R06

   property p_zero_count;
      @(posedge clk_i) disable iff (rst_i)
      publish && !cmd_reads(pend_code) |=> resp_wc == 8'h00;
   endproperty
   a_zero_count: assert property (p_zero_count) else $error("write count not zero"); // R08

   property p_count_step;
      @(posedge clk_i) disable iff (rst_i)
      publish && reply_cnt != 8'hff |=> reply_cnt == $past(reply_cnt) + 8'h01;
   endproperty
   a_count_step: assert property (p_count_step) else $error("reply counter step"); // R11

   property p_count_wrap;
      @(posedge clk_i) disable iff (rst_i)
      publish && reply_cnt == 8'hff |=> reply_cnt == 8'h01;
   endproperty
   a_count_wrap: assert property (p_count_wrap) else $error("reply counter wrap"); // R12

   property p_single_run;
      @(posedge clk_i) disable iff (rst_i)
      accept && cmd_known(out_cmd) |=> head_req_o ##1 !head_req_o;
   endproperty
   a_single_run: assert property (p_single_run) else $error("request not single"); // R13

   property p_repeat_on;
      @(posedge clk_i) disable iff (rst_i)
      st == rfidth_pkg::ST_RPT_IDLE && !accept && !pend_v && !del_req |=> head_req_o;
   endproperty
   a_repeat_on: assert property (p_repeat_on) else $error("repeat stalled"); // R10

   property p_same_tag;
      @(posedge clk_i) disable iff (rst_i)
      st == rfidth_pkg::ST_RPT_EXEC && head_done_i && head_present_i && last_seen &&
         head_status_i == rfidth_pkg::ST_OK && head_data_i == last_data |=> !pend_v;
   endproperty
   a_same_tag: assert property (p_same_tag) else $error("same tag reported"); // R15

   property p_tag_gone;
      @(posedge clk_i) disable iff (rst_i)
      st == rfidth_pkg::ST_RPT_EXEC && head_done_i && !head_present_i && last_seen |=>
         pend_v && pend_stat == 8'h05;
   endproperty
   a_tag_gone: assert property (p_tag_gone) else $error("tag loss not reported"); // R16
endmodule : rfidth_handler

`default_nettype wire

// file: logic/rfidth_pkg.sv
// Constants for the telegram command handler: register map, control bits,
// command codes, status values and reset values.
// Assumes a 32-bit classic Wishbone slave with byte addresses in adr_i[7:0].
package rfidth_pkg;
   // Register byte addresses
   localparam logic [7:0] ADR_OUT_CTRL = 8'h00;
   localparam logic [7:0] ADR_OUT_CMD = 8'h04;
   localparam logic [7:0] ADR_OUT_PARAM = 8'h08;
   localparam logic [7:0] ADR_OUT_DATA = 8'h0c;
   localparam logic [7:0] ADR_IN_CTRL = 8'h10;
   localparam logic [7:0] ADR_IN_RESP = 8'h14;
   localparam logic [7:0] ADR_IN_DATA = 8'h18;
   // Control byte bit positions
   localparam int CTL_US = 0;
   localparam int CTL_UM = 1;
   localparam int CTL_DS = 2;
   // Response word field positions
   localparam int RESP_CODE_LSB = 0;
   localparam int RESP_STAT_LSB = 8;
   localparam int RESP_CNT_LSB = 16;
   localparam int RESP_WC_LSB = 24;
   // Reset values; acknowledge bit starts as the inverse of the update bit
   localparam logic [2:0] OUT_CTRL_RST = 3'h1;
   localparam logic [7:0] RC_RST = 8'h00;
   localparam logic [7:0] RC_MAX = 8'hff;
   localparam logic [7:0] RC_WRAP = 8'h01;
   // Status values
   localparam logic [7:0] ST_OK = 8'h00;
   localparam logic [7:0] ST_TAG_GONE = 8'h05;
   localparam logic [7:0] ST_BAD_CMD = 8'h04;
   localparam logic [7:0] WC_NONE = 8'h00;
   // Command codes
   localparam logic [7:0] select_tag_type_cmd = 8'h04;
   localparam logic [7:0] quit_cmd = 8'h02;
   localparam logic [7:0] config_store_cmd = 8'h17;
   localparam logic [7:0] soft_reset_cmd = 8'h16;
   localparam logic [7:0] multiplexed_mode_cmd = 8'h9b;
   localparam logic [7:0] trigger_mode_cmd = 8'h9c;
   localparam logic [7:0] single_fixed_id_read = 8'h01;
   localparam logic [7:0] repeat_fixed_id_read = 8'h1d;
   localparam logic [7:0] single_word_read = 8'h10;
   localparam logic [7:0] repeat_word_read = 8'h19;
   localparam logic [7:0] single_word_write = 8'h40;
   localparam logic [7:0] repeat_word_write = 8'h1a;
   localparam logic [7:0] single_locked_word_write = 8'h47;
   localparam logic [7:0] repeat_locked_word_write = 8'h48;
   localparam logic [7:0] password_mode_cmd = 8'h18;
   localparam logic [7:0] password_change_cmd = 8'h41;
   localparam logic [7:0] password_supply_cmd = 8'h42;
   localparam logic [7:0] single_config_get = 8'h61;
   localparam logic [7:0] repeat_config_get = 8'h68;
   localparam logic [7:0] single_config_write = 8'h12;
   localparam logic [7:0] repeat_config_write = 8'h66;
   localparam logic [7:0] single_fixed_id_write = 8'h1f;
   localparam logic [7:0] repeat_fixed_id_write = 8'h24;
   localparam logic [7:0] tag_identifier_set = 8'hbc;
   localparam logic [7:0] tag_fill_cmd = 8'haa;
   localparam logic [7:0] single_special_id_read = 8'h0a;
   localparam logic [7:0] repeat_special_id_read = 8'h71;
   localparam logic [7:0] single_special_id_program = 8'h0d;
   localparam logic [7:0] repeat_special_id_program = 8'h75;
   localparam logic [7:0] tag_init_cmd = 8'h6b;
   localparam logic [7:0] head_param_read = 8'hbe;
   localparam logic [7:0] head_param_write = 8'hbf;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RPT_IDLE, ST_RPT_EXEC} rfidth_state_t;
endpackage : rfidth_pkg

// file: tb/rfidth_head_model.sv
// Behavioural read/write head on the far side of the handler's head port.
// Assumes one request at a time; the bench sets delay, tag, count and error.
`timescale 1ns/1ns
`default_nettype none
module rfidth_head_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic [7:0] dly_i,
   input wire logic present_i,
   input wire logic [31:0] id_i,
   input wire logic [7:0] err_i,
   input wire logic [7:0] wc_i,
   output logic done_o,
   output logic [7:0] status_o,
   output logic [7:0] count_o,
   output logic [31:0] data_o,
   output logic present_o
);
   logic busy;
   logic [7:0] cnt;
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         status_o <= 8'h00;
         count_o <= 8'h00;
         data_o <= 32'h0;
         present_o <= 1'b0;
      end else if (req_i) begin
         busy <= 1'b1;
         cnt <= dly_i;
      end else if (busy && cnt == 8'h00) begin
         busy <= 1'b0;
         done_o <= 1'b1;
         status_o <= (err_i != 8'h00) ? err_i : (present_i ? 8'h00 : 8'h05);
         count_o <= wc_i;
         data_o <= present_i ? id_i : 32'h0;
         present_o <= present_i;
      end else begin
         cnt <= cnt - 8'h01;
         // Lines are not held after done, so late sampling shows up
         status_o <= ~status_o;
         count_o <= ~count_o;
         data_o <= ~data_o;
      end
   end
endmodule : rfidth_head_model
`default_nettype wire

// file: tb/test_rfidth_handler.sv
// Self-checking bench for the telegram command handler and a head model.
// Assumes the register map and reply layout of rfidth_pkg.
`timescale 1ns/1ns
`default_nettype none
module test_rfidth_handler;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, chk = 1'b0, rpt = 1'b0;
   logic [7:0] adr = 8'h00, dly = 8'h00, herr = 8'h00, hwc = 8'h03;
   logic [31:0] dat = 32'h0, tag_id = 32'h5a5a0001, dat_o, hdata, hparam, hd_o;
   logic ack_o, hreq, ract, done, hpres, pres = 1'b1;
   logic [7:0] hcode, hstat, hcnt, rc = 8'h00;
   logic [2:0] oc = 3'h1;
   logic us = 1'b0;
   logic [31:0] q_rd[$], q_msk[$], q_pm[$], e, m;
   logic [40:0] q_hd[$], h;
   int err_count = 0, n_tests = 0, seed = 29283, cyc_cnt = 0, n_done = 0, k, i;
   logic [7:0] codes [34] = '{8'h04, 8'h02, 8'h17, 8'h16, 8'h9b, 8'h9c, 8'h01, 8'h1d,
      8'h10, 8'h19, 8'h40, 8'h1a, 8'h47, 8'h48, 8'h18, 8'h41, 8'h42, 8'h61, 8'h68, 8'h12,
      8'h66, 8'h1f, 8'h24, 8'hbc, 8'haa, 8'h0a, 8'h71, 8'h0d, 8'h75, 8'h6b, 8'hbe, 8'hbf,
      8'h55, 8'h10};
   rfidth_handler dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
      .head_req_o(hreq), .head_code_o(hcode), .head_param_o(hparam), .head_data_o(hd_o),
      .repeat_active_o(ract), .head_done_i(done), .head_status_i(hstat),
      .head_count_i(hcnt), .head_data_i(hdata), .head_present_i(hpres));
   rfidth_head_model head_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(hreq), .dly_i(dly),
      .present_i(pres), .id_i(tag_id), .err_i(herr), .wc_i(hwc), .done_o(done),
      .status_o(hstat), .count_o(hcnt), .data_o(hdata), .present_o(hpres));
   always #20 clk_i = ~clk_i;
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   task automatic cmp_reg(input logic [31:0] want, input logic [31:0] got);
      n_tests++;
      if (got !== want) begin
         err_count++;
         $display("[ERR] %0t reg exp %h got %h", $time, want, got);
      end
   endtask : cmp_reg
   task automatic cmp_head(input logic [39:0] want, input logic [39:0] got);
      n_tests++;
      if (got !== want) begin
         err_count++;
         $display("[ERR] %0t head exp %h got %h", $time, want, got);
      end
   endtask : cmp_head
   // Results are taken off the queues as they appear at the ports
   always @(posedge clk_i) begin
      if (cyc && !we && ack_o === 1'b1 && chk && q_rd.size() > 0) begin
         e = q_rd.pop_front();
         m = q_msk.pop_front();
         cmp_reg(e, dat_o & m);
      end
      if (hreq === 1'b1 && q_hd.size() > 0) begin
         h = q_hd.pop_front();
         e = q_pm.pop_front();
         cmp_head(h[39:0], {hcode, hd_o & {32{h[40]}}});
         cmp_reg(e, hparam);
      end
      if (done === 1'b1) n_done++;
      cyc_cnt++;
      if (cyc_cnt > 60000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
         output logic [31:0] r);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      chk <= c;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk <= 1'b0;
      if (n >= 40) err_count++;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, 1'b0, r);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
      logic [31:0] r;
      q_rd.push_back(ex & mk);
      q_msk.push_back(mk);
      wb(1'b0, a, 32'h0, 1'b1, r);
   endtask : rdc
   task automatic issue(input logic [7:0] c, input logic [31:0] d, input logic q);
      logic [31:0] r, p;
      p = $random(seed);
      if (q) q_pm.push_back(p);
      wr(rfidth_pkg::ADR_OUT_CMD, {24'h0, c});
      wr(rfidth_pkg::ADR_OUT_PARAM, p);
      wr(rfidth_pkg::ADR_OUT_DATA, d);
      wb(1'b0, rfidth_pkg::ADR_IN_CTRL, 32'h0, 1'b0, r);
      if (oc[1] != r[1]) oc[1] = r[1];
      wr(rfidth_pkg::ADR_OUT_CTRL, {29'h0, oc});
   endtask : issue
   task automatic resp(input logic [7:0] c, input logic [7:0] st, input logic [7:0] wc,
         input logic [7:0] wm, input logic [31:0] id, input logic [31:0] im);
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         wb(1'b0, rfidth_pkg::ADR_IN_CTRL, 32'h0, 1'b0, r);
         n++;
      end while (r[0] === us && n < 100);
      if (n >= 100) err_count++;
      us = ~us;
      rc = (rc == 8'hff) ? 8'h01 : rc + 8'h01;
      rdc(rfidth_pkg::ADR_IN_CTRL, {29'h0, oc[2], ~oc[1], us}, 32'h7);
      rdc(rfidth_pkg::ADR_IN_RESP, {wc, rc, st, c}, {wm, 24'hffffff});
      rdc(rfidth_pkg::ADR_IN_DATA, id, im);
      oc[0] = ~us;
      wr(rfidth_pkg::ADR_OUT_CTRL, {29'h0, oc});
   endtask : resp
   task automatic run(input logic [7:0] c);
      logic [1:0] kd;
      logic [31:0] d;
      kd = (c inside {8'h10, 8'h19}) ? 2'h2 : (c inside {8'h01, 8'h1d}) ? 2'h3 :
         (c inside {8'h40, 8'h1a, 8'h47, 8'h48, 8'h1f, 8'h24, 8'h04, 8'h02, 8'h17, 8'h16,
         8'h9b, 8'h9c}) ? 2'h1 : 2'h0;
      d = $random(seed);
      if (!rpt && c != 8'h55) q_hd.push_back({kd[1], c, 32'h0});
      issue(c, d, !rpt && c != 8'h55);
      resp(c, (c == 8'h55) ? 8'h04 : 8'h00, (kd == 2'h2) ? hwc : 8'h00,
         (kd == 2'h0) ? 8'h00 : 8'hff, tag_id, kd[1] ? 32'hffffffff : 32'h0);
      rpt = c inside {8'h1d, 8'h19, 8'h1a, 8'h48, 8'h68, 8'h66, 8'h24, 8'h71, 8'h75};
      cmp_reg({31'h0, rpt}, {31'h0, ract});
   endtask : run
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdc(rfidth_pkg::ADR_IN_CTRL, 32'h2, 32'hffffffff);
      wr(rfidth_pkg::ADR_IN_RESP, 32'hffffffff);
      rdc(rfidth_pkg::ADR_IN_RESP, 32'h0, 32'hffffffff);
      rdc(8'h40, 32'h0, 32'hffffffff);
      // Every code, random delays, and enough replies to wrap the counter
      for (i = 0; i < 272; i++) begin
         dly <= $random(seed) & 8'h0f;
         hwc <= $random(seed);
         run(codes[i % 34]);
      end
      run(8'h19);
      repeat (30) @(posedge clk_i);
      rdc(rfidth_pkg::ADR_IN_CTRL, {29'h0, oc[2], ~oc[1], us}, 32'h7);
      tag_id <= $random(seed);
      @(posedge clk_i);
      resp(8'h19, 8'h00, hwc, 8'hff, tag_id, 32'hffffffff);
      pres <= 1'b0;
      resp(8'h19, 8'h05, 8'h00, 8'h00, 32'h0, 32'hffffffff);
      pres <= 1'b1;
      herr <= 8'h33;
      resp(8'h19, 8'h33, 8'h00, 8'h00, 32'h0, 32'h0);
      herr <= 8'h00;
      rpt = 1'b0;
      cmp_reg(32'h0, {31'h0, ract});
      // Hold the reply back, then drop it with the delete bit
      oc[0] = us;
      k = n_done;
      q_hd.push_back({1'b1, 8'h10, 32'h0});
      issue(8'h10, 32'h0, 1'b1);
      for (i = 0; i < 100 && n_done == k; i++) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      oc[2] = ~oc[2];
      wr(rfidth_pkg::ADR_OUT_CTRL, {29'h0, oc});
      oc[0] = ~us;
      wr(rfidth_pkg::ADR_OUT_CTRL, {29'h0, oc});
      repeat (10) @(posedge clk_i);
      rdc(rfidth_pkg::ADR_IN_CTRL, {29'h0, oc[2], ~oc[1], us}, 32'h7);
      run(8'h01);
      finish_test();
   end
endmodule : test_rfidth_handler
`default_nettype wire
